// [pkg/gpio_pkg.sv]
`default_nettype none

package gpio_pkg;

   // ==========================================================
   // Register offsets in I/O space
   localparam logic [7:0] OFF_PORT_D_PIN_LEVELS = 8'h10;
   localparam logic [7:0] OFF_PORT_D_DIRECTION = 8'h11;
   localparam logic [7:0] OFF_PORT_D_OUTPUT_LATCH = 8'h12;
   localparam logic [7:0] OFF_PORT_C_PIN_LEVELS = 8'h13;
   localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h14;
   localparam logic [7:0] OFF_PORT_C_OUTPUT_LATCH = 8'h15;
   localparam logic [7:0] OFF_PORT_B_PIN_LEVELS = 8'h16;
   localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h17;
   localparam logic [7:0] OFF_PORT_B_OUTPUT_LATCH = 8'h18;
   localparam logic [7:0] OFF_PORT_A_PIN_LEVELS = 8'h19;
   localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h1A;
   localparam logic [7:0] OFF_PORT_A_OUTPUT_LATCH = 8'h1B;

   // Distance from an I/O address to its data-memory alias
   localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
   // Addresses per port
   localparam logic [7:0] REGS_PER_PORT = 8'h03;

   // ==========================================================
   // Register kinds within one port, and port indices
   localparam logic [1:0] KIND_PINS = 2'h0;
   localparam logic [1:0] KIND_DIR = 2'h1;
   localparam logic [1:0] KIND_LATCH = 2'h2;
   localparam logic [1:0] PORT_A_IDX = 2'h0;
   localparam logic [1:0] PORT_B_IDX = 2'h1;
   localparam logic [1:0] PORT_C_IDX = 2'h2;
   localparam logic [1:0] PORT_D_IDX = 2'h3;

   // ==========================================================
   // Reset and default values
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ==========================================================
   // Alternate-function bit positions
   localparam int B_T0_BIT = 0;
   localparam int B_T1_BIT = 1;
   localparam int B_SELECT_BIT = 4;
   localparam int B_MOSI_BIT = 5;
   localparam int B_MISO_BIT = 6;
   localparam int B_SCK_BIT = 7;
   localparam int D_RX_BIT = 0;
   localparam int D_TX_BIT = 1;
   localparam int D_IRQ0_BIT = 2;
   localparam int D_IRQ1_BIT = 3;
   localparam int D_CMPA_BIT = 5;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [7:0] d;
      logic [7:0] c;
      logic [7:0] b;
      logic [7:0] a;
   } port_bank_t;

   typedef logic [3:0][7:0] bank_arr_t;

   typedef struct packed {
      logic hit;
      logic [1:0] port;
      logic [1:0] kind;
   } decode_t;

   typedef struct packed {
      logic uart_tx_en;
      logic uart_tx_val;
      logic compare_a_en;
      logic compare_a_val;
      logic spi_mosi_en;
      logic spi_mosi_val;
      logic spi_miso_en;
      logic spi_miso_val;
      logic spi_sck_en;
      logic spi_sck_val;
   } alt_drive_t;

   typedef struct packed {
      logic timer_zero_count_input;
      logic timer_one_count_input;
      logic spi_select_in;
      logic spi_mosi_in;
      logic spi_miso_in;
      logic spi_sck_in;
      logic uart_rx_in;
      logic external_irq_zero;
      logic external_irq_one;
   } alt_sense_t;

endpackage

`default_nettype wire

// [rtl/pin_sync.sv]
`default_nettype none

module pin_sync
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire port_bank_t pin_in,
   output port_bank_t pin_level
);

   port_bank_t meta_r;
   port_bank_t level_r;

   // ==========================================================
   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         meta_r <= '0;
         level_r <= '0;
      end else begin
         meta_r <= pin_in;
         level_r <= meta_r;
      end
   end

   assign pin_level = level_r;

endmodule

`default_nettype wire

// [rtl/gpio_ports.sv]
// Operation
// - Direction bit one makes the pin an output, zero an input.
// - Output pins drive push-pull to their latch bit level.
// - Third-port input pins float; their latch bit has no effect.
// - Pull-up on only while pin is input and its latch bit is one.
// - Second and fourth ports have no pull-ups; inputs stay floating.
// - Reset floats every pin at once, without needing the clock.
// - Reading a data register returns the output latch, not pins.
// - Reading the input-pins address returns pin levels after the two-stage synchroniser.
// - Input-pins address is read-only; data and direction are read/write.
// - Three addresses per port, also mirrored 0x20 higher in memory.
// - Second port bits double as timer inputs and serial-peripheral pins.
// - Fourth port bits double as UART, external interrupts, compare output.
`default_nettype none

module gpio_ports
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] io_addr,
   input wire logic mem_space,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire port_bank_t pin_in,
   output port_bank_t pin_out,
   output port_bank_t pin_oe,
   output logic [7:0] pullup_en,
   input wire alt_drive_t alt_drive,
   output alt_sense_t alt_sense
);

   // ==========================================================
   // Helper functions

   // Address decode shared by the write and read paths
   function automatic decode_t decode(input logic [7:0] addr,
                                      input logic mem);
      decode_t d;
      logic [7:0] a;
      logic [7:0] idx;
      logic [7:0] grp;
      logic [7:0] rem;
      d = '0;
      a = mem ? addr - DATA_SPACE_OFFSET : addr;
      idx = a - OFF_PORT_D_PIN_LEVELS;
      grp = idx / REGS_PER_PORT;
      rem = idx % REGS_PER_PORT;
      d.hit = (a >= OFF_PORT_D_PIN_LEVELS) &&
              (a <= OFF_PORT_A_OUTPUT_LATCH) &&
              !(mem && (addr < DATA_SPACE_OFFSET));
      d.port = PORT_D_IDX - grp[1:0];
      d.kind = rem[1:0];
      return d;
   endfunction

   // Select a peripheral level in place of the latch level
   function automatic logic pick(input logic latch_bit,
                                 input logic en,
                                 input logic val);
      return en ? val : latch_bit;
   endfunction

   // ==========================================================
   // Storage and decode

   bank_arr_t dir_r;
   bank_arr_t latch_r;
   bank_arr_t out_r;
   bank_arr_t out_nxt;
   logic [7:0] pullup_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   port_bank_t level_s;
   bank_arr_t level_arr;
   decode_t wr_dec;
   decode_t rd_dec;

   assign wr_dec = decode(io_addr, mem_space);
   assign rd_dec = decode(io_addr, mem_space);
   assign level_arr = bank_arr_t'(level_s);

   // Pin levels brought into the clock domain
   pin_sync u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .pin_in(pin_in),
      .pin_level(level_s)
   );

   // ==========================================================
   // Direction registers; cleared without the clock on reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dir_r <= {4{DIR_RESET}};
      end else if (io_wr && wr_dec.hit && wr_dec.kind == KIND_DIR) begin
         dir_r[wr_dec.port] <= io_wdata;
      end
   end

   // Output latch registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         latch_r <= {4{LATCH_RESET}};
      end else if (io_wr && wr_dec.hit &&
                   wr_dec.kind == KIND_LATCH) begin
         latch_r[wr_dec.port] <= io_wdata;
      end
   end

   // ==========================================================
   // Drive levels: latch, with peripheral outputs substituted
   always_comb begin
      out_nxt = latch_r;
      out_nxt[PORT_D_IDX][D_TX_BIT] = pick(latch_r[PORT_D_IDX][D_TX_BIT],
         alt_drive.uart_tx_en, alt_drive.uart_tx_val);
      out_nxt[PORT_D_IDX][D_CMPA_BIT] =
         pick(latch_r[PORT_D_IDX][D_CMPA_BIT],
         alt_drive.compare_a_en, alt_drive.compare_a_val);
      out_nxt[PORT_B_IDX][B_MOSI_BIT] =
         pick(latch_r[PORT_B_IDX][B_MOSI_BIT],
         alt_drive.spi_mosi_en, alt_drive.spi_mosi_val);
      out_nxt[PORT_B_IDX][B_MISO_BIT] =
         pick(latch_r[PORT_B_IDX][B_MISO_BIT],
         alt_drive.spi_miso_en, alt_drive.spi_miso_val);
      out_nxt[PORT_B_IDX][B_SCK_BIT] =
         pick(latch_r[PORT_B_IDX][B_SCK_BIT],
         alt_drive.spi_sck_en, alt_drive.spi_sck_val);
   end

   // Registered drive level; enable alone decides whether it reaches the pin
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         out_r <= {4{LATCH_RESET}};
      end else begin
         out_r <= out_nxt;
      end
   end

   // ==========================================================
   // Pull-up on the first port only; other ports have none
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pullup_r <= DIR_RESET;
      end else begin
         pullup_r <= ~dir_r[PORT_A_IDX] & latch_r[PORT_A_IDX];
      end
   end

   // ==========================================================
   // Read path; the pins address returns synchronised levels
   always_comb begin
      rdata_nxt = READ_UNMAPPED;
      if (rd_dec.hit) begin
         unique case (rd_dec.kind)
            KIND_PINS: rdata_nxt = level_arr[rd_dec.port];
            KIND_DIR: rdata_nxt = dir_r[rd_dec.port];
            KIND_LATCH: rdata_nxt = latch_r[rd_dec.port];
            default: rdata_nxt = READ_UNMAPPED;
         endcase
      end
   end

   // Read data register, updated on each read strobe
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_r <= READ_UNMAPPED;
      end else if (io_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Outputs; the enable follows the direction bit directly
   assign io_rdata = rdata_r;
   assign pin_oe = port_bank_t'(dir_r);
   assign pin_out = port_bank_t'(out_r);
   assign pullup_en = pullup_r;

   // Synchronised levels handed to the peripherals
   assign alt_sense.timer_zero_count_input = level_s.b[B_T0_BIT];
   assign alt_sense.timer_one_count_input = level_s.b[B_T1_BIT];
   assign alt_sense.spi_select_in = level_s.b[B_SELECT_BIT];
   assign alt_sense.spi_mosi_in = level_s.b[B_MOSI_BIT];
   assign alt_sense.spi_miso_in = level_s.b[B_MISO_BIT];
   assign alt_sense.spi_sck_in = level_s.b[B_SCK_BIT];
   assign alt_sense.uart_rx_in = level_s.d[D_RX_BIT];
   assign alt_sense.external_irq_zero = level_s.d[D_IRQ0_BIT];
   assign alt_sense.external_irq_one = level_s.d[D_IRQ1_BIT];

   // ==========================================================
   // Checks

   // Direction write shows on the enables one edge later
   property p_dir_write_enables;
      @(posedge mclk) disable iff (!rstn)
      (io_wr && !mem_space && io_addr == OFF_PORT_D_DIRECTION)
         |-> ##1 pin_oe.d == $past(io_wdata);
   endproperty
   a_dir_write_enables:
      assert property (p_dir_write_enables)
      else $error("direction write did not reach pin enables");

   // Port C drives its latch two edges after it was written
   property p_latch_drives_pin;
      @(posedge mclk) disable iff (!rstn)
      (io_wr && ((!mem_space && io_addr == OFF_PORT_C_OUTPUT_LATCH) ||
         (mem_space &&
         io_addr == OFF_PORT_C_OUTPUT_LATCH + DATA_SPACE_OFFSET)))
         ##1 (!io_wr) |-> ##1 pin_out.c == $past(io_wdata, 2);
   endproperty
   a_latch_drives_pin:
      assert property (p_latch_drives_pin)
      else $error("latch value not driven on pins");

   // Port C pins written as inputs are never driven, whatever the latch
   property p_c_input_floats;
      @(posedge mclk) disable iff (!rstn)
      (io_wr && !mem_space && io_addr == OFF_PORT_C_DIRECTION)
         |-> ##1 (pin_oe.c & ~$past(io_wdata)) == 8'h00;
   endproperty
   a_c_input_floats:
      assert property (p_c_input_floats)
      else $error("port C input pin driven");

   // Pull-up follows input-and-latch-one one edge later
   property p_pullup_rule;
      @(posedge mclk) disable iff (!rstn)
      ##1 pullup_en ==
         ($past(~dir_r[PORT_A_IDX]) & $past(latch_r[PORT_A_IDX]));
   endproperty
   a_pullup_rule:
      assert property (p_pullup_rule)
      else $error("pull-up enable wrong");

   // Output selection turns the pull-up off
   property p_output_no_pullup;
      @(posedge mclk) disable iff (!rstn)
      (dir_r[PORT_A_IDX] == 8'hFF) ##1 (dir_r[PORT_A_IDX] == 8'hFF)
         |-> pullup_en == 8'h00;
   endproperty
   a_output_no_pullup:
      assert property (p_output_no_pullup)
      else $error("pull-up on while pin is an output");

   // In reset every pin is released
   property p_reset_floats;
      @(posedge mclk) disable iff (1'b0)
      !rstn |-> (pin_oe == '0) && (pullup_en == 8'h00);
   endproperty
   a_reset_floats:
      assert property (p_reset_floats)
      else $error("pin driven during reset");

   // Latch read returns the latch, not the pins
   property p_latch_read;
      @(posedge mclk) disable iff (!rstn)
      (io_rd && !mem_space && io_addr == OFF_PORT_B_OUTPUT_LATCH)
         |-> ##1 io_rdata == $past(latch_r[PORT_B_IDX]);
   endproperty
   a_latch_read:
      assert property (p_latch_read)
      else $error("latch read returned wrong value");

   // Pin read returns the level sampled three edges earlier
   property p_pin_read;
      @(posedge mclk) disable iff (!rstn)
      (io_rd && !mem_space && io_addr == OFF_PORT_C_PIN_LEVELS)
         ##1 $past(rstn, 3) |-> io_rdata == $past(pin_in.c, 3);
   endproperty
   a_pin_read:
      assert property (p_pin_read)
      else $error("pin read not the synchronised level");

   // Writing the pins address changes no stored state
   property p_pins_read_only;
      @(posedge mclk) disable iff (!rstn)
      (io_wr && !mem_space && io_addr == OFF_PORT_D_PIN_LEVELS)
         |-> ##1 (dir_r == $past(dir_r)) && (latch_r == $past(latch_r));
   endproperty
   a_pins_read_only:
      assert property (p_pins_read_only)
      else $error("write to pins address changed a register");

   // Data-memory alias reads the same direction register
   property p_alias_read;
      @(posedge mclk) disable iff (!rstn)
      (io_rd && mem_space &&
       io_addr == OFF_PORT_D_DIRECTION + DATA_SPACE_OFFSET)
         |-> ##1 io_rdata == $past(dir_r[PORT_D_IDX]);
   endproperty
   a_alias_read:
      assert property (p_alias_read)
      else $error("data-memory alias read wrong");

   // Timer count input is the pin level two edges late
   property p_timer_sense;
      @(posedge mclk) disable iff (!rstn)
      $past(rstn, 2) |->
         alt_sense.timer_zero_count_input == $past(pin_in.b[B_T0_BIT], 2);
   endproperty
   a_timer_sense:
      assert property (p_timer_sense)
      else $error("timer count input not synchronised pin");

   // UART transmit level replaces the latch on its pin
   property p_uart_drive;
      @(posedge mclk) disable iff (!rstn)
      alt_drive.uart_tx_en |->
         ##1 pin_out.d[D_TX_BIT] == $past(alt_drive.uart_tx_val);
   endproperty
   a_uart_drive:
      assert property (p_uart_drive)
      else $error("transmit level not on pin");

   // Data-space addresses below the alias window read as zero
   property p_unmapped_read;
      @(posedge mclk) disable iff (!rstn)
      (io_rd && mem_space && io_addr < DATA_SPACE_OFFSET)
         |-> ##1 io_rdata == READ_UNMAPPED;
   endproperty
   a_unmapped_read:
      assert property (p_unmapped_read)
      else $error("unmapped data-space read not zero");

   // Read data stands until the next read strobe
   property p_rdata_holds;
      @(posedge mclk) disable iff (!rstn)
      !io_rd |-> ##1 $stable(io_rdata);
   endproperty
   a_rdata_holds:
      assert property (p_rdata_holds)
      else $error("read data changed without a read");

   // Pin enables change only on a register write
   property p_dir_hold;
      @(posedge mclk) disable iff (!rstn)
      !io_wr |-> ##1 pin_oe == $past(pin_oe);
   endproperty
   a_dir_hold:
      assert property (p_dir_hold)
      else $error("pin enables changed without a write");

   // Port A latch written through its alias drives the pins
   property p_alias_write;
      @(posedge mclk) disable iff (!rstn)
      (io_wr && mem_space &&
       io_addr == OFF_PORT_A_OUTPUT_LATCH + DATA_SPACE_OFFSET)
         |-> ##2 pin_out.a == $past(io_wdata, 2);
   endproperty
   a_alias_write:
      assert property (p_alias_write)
      else $error("alias latch write not driven on pins");

endmodule

`default_nettype wire

// [bench/pin_partner.sv]
`default_nettype none

// ======================================
// Outside circuitry wired to the pads
module pin_partner
   import gpio_pkg::*;
(
   input wire logic mclk,
   input wire port_bank_t pin_out,
   input wire port_bank_t pin_oe,
   input wire logic [7:0] pullup_en,
   input wire port_bank_t ext_val,
   input wire port_bank_t ext_en,
   output port_bank_t pin_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic flt_r = 1'b0;

   // Undriven lines wander, so a stale level never passes
   always @(posedge mclk) flt_r <= ~flt_r;

   // Resolve each wire: device first, then outside driver, then pull-up
   always_comb begin
      pin_in = {32{flt_r}};
      for (int i = 0; i < 32; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (i < 8 && pullup_en[i % 8]) pin_in[i] = 1'b1;
      end
   end
endmodule

`default_nettype wire

// [bench/testbench.sv]
`default_nettype none

// ======================================
// Self-checking bench for the port bank
module testbench
   import gpio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 1'b0;
   logic rstn, mem_space, io_wr, io_rd;
   logic [7:0] io_addr, io_wdata, io_rdata, pullup_en, rv;
   port_bank_t pin_in, pin_out, pin_oe, ext_val, ext_en, eo, el, ep;
   alt_drive_t alt_drive;
   alt_sense_t alt_sense;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] base [4];

   gpio_ports gpio_ports_i (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
      .mem_space(mem_space), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .alt_drive(alt_drive), .alt_sense(alt_sense));

   pin_partner pin_partner_i (.mclk(mclk), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_val(ext_val),
      .ext_en(ext_en), .pin_in(pin_in));

   // Clock and hang guard
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // ======================================
   // Bus tasks
   task automatic wr(input logic [7:0] a, input logic m, input logic [7:0] d);
      @(posedge mclk);
      #1;
      io_addr = a;
      mem_space = m;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge mclk);
      #1;
      io_wr = 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rchk(input string n, input logic [7:0] a, input logic m,
                       input logic [7:0] e);
      @(posedge mclk);
      #1;
      io_addr = a;
      mem_space = m;
      io_rd = 1'b1;
      @(posedge mclk);
      #1;
      io_rd = 1'b0;
      @(posedge mclk);
      #1;
      rv = io_rdata;
      chk(n, {24'h0, e}, {24'h0, rv});
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ======================================
   // Main sequence
   initial begin
      base = '{OFF_PORT_A_PIN_LEVELS, OFF_PORT_B_PIN_LEVELS,
               OFF_PORT_C_PIN_LEVELS, OFF_PORT_D_PIN_LEVELS};
      rstn = 1'b1;
      mem_space = 1'b0;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      alt_drive = '0;
      ext_val = 32'hC3C3C3C3;
      ext_en = 32'hFFFFFF00;
      // Reset falls after time zero so the asynchronous clear is seen
      #1;
      rstn = 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      rstn = 1'b1;
      // Reset contents and floating pins
      for (int p = 0; p < 4; p++) begin
         rchk("dir reset", base[p] + 8'h01, 1'b0, 8'h00);
         rchk("latch reset", base[p] + 8'h02, 1'b0, 8'h00);
      end
      chk("oe after reset", 32'h0, pin_oe);
      // Program every port, latches through the memory alias
      for (int p = 0; p < 4; p++) begin
         eo[p*8 +: 8] = 8'h0F << p;
         el[p*8 +: 8] = 8'hF0 >> p;
         ep[p*8 +: 8] = (el[p*8 +: 8] & eo[p*8 +: 8]) |
            ((p == 0 ? el[p*8 +: 8] : 8'hC3) & ~eo[p*8 +: 8]);
         wr(base[p] + 8'h01, 1'b0, eo[p*8 +: 8]);
         wr(base[p] + 8'h22, 1'b1, el[p*8 +: 8]);
      end
      for (int p = 0; p < 4; p++) begin
         rchk("dir alias", base[p] + 8'h21, 1'b1, eo[p*8 +: 8]);
         rchk("latch", base[p] + 8'h02, 1'b0, el[p*8 +: 8]);
         rchk("pins", base[p], 1'b0, ep[p*8 +: 8]);
      end
      chk("oe", eo, pin_oe);
      chk("drive", el & eo, pin_out & pin_oe);
      chk("pullup", 32'hF0, {24'h0, pullup_en});
      // Pins address refuses writes
      wr(base[3], 1'b0, 8'hFF);
      wr(8'h32, 1'b0, 8'hFF);
      rchk("latch kept", base[3] + 8'h02, 1'b0, el[31:24]);
      rchk("pins kept", base[3], 1'b0, ep[31:24]);
      rchk("unmapped", 8'h12, 1'b1, 8'h00);
      // Output mode turns the pull-up off
      wr(base[0] + 8'h01, 1'b0, 8'hFF);
      repeat (2) @(posedge mclk);
      #1;
      chk("pullup off", 32'h0, {24'h0, pullup_en});
      // Peripheral inputs see synchronised pin levels
      wr(base[1] + 8'h01, 1'b0, 8'h00);
      wr(base[3] + 8'h01, 1'b0, 8'h00);
      ext_val = 32'h09C351C3;
      repeat (3) @(posedge mclk);
      #1;
      chk("alt sense", 32'h155, {23'h0, alt_sense});
      // Peripheral drive overrides on output pins
      wr(base[1] + 8'h01, 1'b0, 8'hFF);
      wr(base[3] + 8'h01, 1'b0, 8'hFF);
      wr(base[3] + 8'h02, 1'b0, 8'h00);
      alt_drive = 10'b1110101111;
      repeat (3) @(posedge mclk);
      #1;
      chk("alt drive d", 32'h02, {24'h0, pin_out.d});
      chk("alt drive b", 32'hD8, {24'h0, pin_out.b});
      // Reset mid-run floats pins before any clock edge
      wr(base[0] + 8'h01, 1'b0, 8'h0F);
      @(posedge mclk);
      #1;
      rstn = 1'b0;
      #1;
      chk("oe in reset", 32'h0, pin_oe);
      chk("pullup in reset", 32'h0, {24'h0, pullup_en});
      repeat (3) @(posedge mclk);
      #1;
      rstn = 1'b1;
      rchk("latch after reset", base[0] + 8'h02, 1'b0, 8'h00);
      report_and_stop();
   end
endmodule

`default_nettype wire
